/* File: hdl/hsfs_pkg.sv */
// Purpose: shared constants for the high side fault supervisor
// Assumes: 250 MHz system clock, 8-bit serial frames
// Notes:   status byte layout and command codes live here
package hsfs_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int TRIP_DLY0_NS = 100;
  localparam int TRIP_DLY1_NS = 200;
  localparam int TRIP_DLY2_NS = 400;
  localparam int TRIP_DLY3_NS = 800;
  // all times round down to whole cycles; the shortest is 25 cycles
  localparam int TRIP_DLY0_CYC = (TRIP_DLY0_NS * CLK_MHZ) / 1000;
  localparam int TRIP_DLY1_CYC = (TRIP_DLY1_NS * CLK_MHZ) / 1000;
  localparam int TRIP_DLY2_CYC = (TRIP_DLY2_NS * CLK_MHZ) / 1000;
  localparam int TRIP_DLY3_CYC = (TRIP_DLY3_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 10;
  // ==========================================================
  // status byte bit positions
  localparam int ST_UV  = 0;
  localparam int ST_OV  = 1;   // status_bit_one
  localparam int ST_OL0 = 2;
  localparam int ST_OT0 = 4;
  localparam int ST_OC0 = 6;
  // ==========================================================
  // command word fields and register codes
  localparam int CMD_SEL = 7;
  localparam logic [2:0] CMD_STAT = 3'h0;
  localparam logic [2:0] CMD_OUT  = 3'h1;
  localparam logic [2:0] CMD_TRIP = 3'h2;
  localparam logic [2:0] CMD_DLY  = 3'h3;
  localparam logic [2:0] CMD_SUP  = 3'h6;
  localparam int OUT_ON0 = 0;
  localparam int OUT_ON1 = 2;
  localparam int TRIP_HI = 3;
  localparam int DLY_OLD = 3;
  localparam int SUP_UVD = 1;
  localparam int SUP_OVD = 0;
  // ==========================================================
  // configuration reset values
  localparam logic [2:0] LOW_LVL_RST = 3'h0;
  localparam logic       HI_LVL_RST  = 1'h0;
  localparam logic [1:0] DLY_RST     = 2'h0;
  localparam logic       DIS_RST     = 1'h0;
endpackage

/* File: hdl/hsfs_supervisor.sv */
// Purpose: fault supervision for a dual high side switch
// Assumes: analog comparators arrive as pins; serial link on its own clock
// Notes:   status is sticky, cleared by a valid frame
// Functional notes
// - logic supply loss resets configuration; direct inputs still drive outputs.
// - without logic supply, protections keep running on default settings.
// - fault pin goes low on any temperature, load, current or supply fault.
// - fault pin self-releases except over-current and latched under-voltage.
// - faults held in status, shifted out and cleared by first valid frame.
// - over-temperature only sensed while on; output off until cooled, repeats.
// - over-temperature flag sticky until valid read or reset.
// - over-voltage holds output off; flag at status bit one until read.
// - overvoltage_disable turns off over-voltage protection and its flag.
// - low supply turns output off, pulls fault pin, sets undervoltage flag.
// - recovery with command low releases fault pin, flag stays until read.
// - recovery with command on keeps output off until command toggles.
// - undervoltage_disable hides under-voltage and leaves output unchanged.
// - open-load sensed only while off, latched once gate is pulled low.
// - open-load flag clears on read once the condition is gone.
// - open_load_disable turns off open-load detection.
// - eight low trip levels, two high levels, one of each monitored.
// - low trip held beyond low_trip_delay latches the output off.
// - high trip latches the output off at once, no delay.
// - current-latched output stays off until commanded off then on.
// - command is direct input or serial_on_command bit, either counts.
// - with command low, under-voltage is not latched; pin follows supply.
// - chip select falling loads status into the snapshot register read out on SO.
module hsfs_supervisor (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        logic_supply_ok_in,
  input  wire logic [1:0]  direct_inputs_in,
  input  wire logic [1:0]  overtemp_in,
  input  wire logic        overvolt_in,
  input  wire logic        supply_low_in,
  input  wire logic [1:0]  open_load_in,
  input  wire logic [1:0]  gate_low_in,
  input  wire logic [15:0] low_trip_cmp_in,
  input  wire logic [3:0]  high_trip_cmp_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_si_in,
  output logic             spi_so_out,
  output logic             spi_so_oe_n_out,
  output logic [1:0]       switch_on_out,
  output logic             fault_pin_n_out,
  output logic [7:0]       status_out
);
  // ==========================================================
  // pin synchronisers
  localparam int PW = 32;
  logic [PW-1:0] pin_meta_reg;
  logic [PW-1:0] pin_sync_reg;
  always_ff @(posedge sys_clk_in) begin
    pin_meta_reg <= {logic_supply_ok_in, direct_inputs_in, overtemp_in, overvolt_in,
                     supply_low_in, open_load_in, gate_low_in, low_trip_cmp_in,
                     high_trip_cmp_in, spi_cs_n_in};
    pin_sync_reg <= pin_meta_reg;
  end
  logic        vdd_ok, ov_in, uv_in, cs_s, cs_prev_reg;
  logic [1:0]  dir_in, ot_in, ol_in, gl_in;
  logic [15:0] ocl_in;
  logic [3:0]  och_in;
  assign {vdd_ok, dir_in, ot_in, ov_in, uv_in, ol_in, gl_in, ocl_in, och_in, cs_s}
    = pin_sync_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cs_prev_reg <= 1'h1;
    end else begin
      cs_prev_reg <= cs_s;
    end
  end
  wire cs_fall = cs_prev_reg & ~cs_s;
  wire cs_rise = ~cs_prev_reg & cs_s;

  // ==========================================================
  // link side: shifts on the serial clock, counters and byte flag cleared while deselected
  logic [7:0] rx_shift_reg;
  logic [2:0] rx_cnt_reg;
  logic       rx_byte_reg;
  logic [2:0] tx_cnt_reg;
  logic [7:0] snap_reg;
  always_ff @(negedge spi_sclk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      rx_cnt_reg  <= 3'h0;
      rx_byte_reg <= 1'h0;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + 3'h1;
      if (rx_cnt_reg == 3'h7) begin
        rx_byte_reg <= 1'h1;
      end
    end
  end
  always_ff @(negedge spi_sclk_in) begin
    if (!spi_cs_n_in) begin
      rx_shift_reg <= {rx_shift_reg[6:0], spi_si_in};
    end
  end
  always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      tx_cnt_reg <= 3'h0;
    end else begin
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
    end
  end
  // verdict and command are taken as chip select rises, ahead of the
  // counter clear; both then stand until the next frame ends
  logic       frame_good_reg;
  logic [7:0] cmd_reg;
  always_ff @(posedge spi_cs_n_in) begin
    frame_good_reg <= rx_byte_reg & (rx_cnt_reg == 3'h0);
    cmd_reg        <= rx_shift_reg;
  end
  // snapshot is stable for the whole frame, so the link may read it
  assign spi_so_out      = snap_reg[~tx_cnt_reg];
  assign spi_so_oe_n_out = spi_cs_n_in;

  // ==========================================================
  // frame end: captured verdict settles long before the synced rise
  logic       frame_ok;
  logic [7:0] cmd;
  assign frame_ok = cs_rise & frame_good_reg;
  assign cmd      = cmd_reg;

  // ==========================================================
  // configuration
  logic [1:0] serial_on_reg;
  logic [2:0] low_lvl_reg [2];
  logic [1:0] high_lvl_reg;
  logic [1:0] dly_reg [2];
  logic [1:0] open_load_disable_reg;
  logic       overvoltage_disable_reg;
  logic       undervoltage_disable_reg;
  wire        sel = cmd[hsfs_pkg::CMD_SEL];
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !vdd_ok) begin
      serial_on_reg            <= 2'h0;
      low_lvl_reg[0]           <= hsfs_pkg::LOW_LVL_RST;
      low_lvl_reg[1]           <= hsfs_pkg::LOW_LVL_RST;
      high_lvl_reg             <= {2{hsfs_pkg::HI_LVL_RST}};
      dly_reg[0]               <= hsfs_pkg::DLY_RST;
      dly_reg[1]               <= hsfs_pkg::DLY_RST;
      open_load_disable_reg    <= {2{hsfs_pkg::DIS_RST}};
      overvoltage_disable_reg  <= hsfs_pkg::DIS_RST;
      undervoltage_disable_reg <= hsfs_pkg::DIS_RST;
    end else if (frame_ok) begin
      case (cmd[6:4])
        hsfs_pkg::CMD_OUT: begin
          serial_on_reg <= {cmd[hsfs_pkg::OUT_ON1], cmd[hsfs_pkg::OUT_ON0]};
        end
        hsfs_pkg::CMD_TRIP: begin
          low_lvl_reg[sel]  <= cmd[2:0];
          high_lvl_reg[sel] <= cmd[hsfs_pkg::TRIP_HI];
        end
        hsfs_pkg::CMD_DLY: begin
          dly_reg[sel]               <= cmd[1:0];
          open_load_disable_reg[sel] <= cmd[hsfs_pkg::DLY_OLD];
        end
        hsfs_pkg::CMD_SUP: begin
          if (sel) begin
            undervoltage_disable_reg <= cmd[hsfs_pkg::SUP_UVD];
            overvoltage_disable_reg  <= cmd[hsfs_pkg::SUP_OVD];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // supply conditions shared by both outputs
  logic ov_now, uv_now;
  assign ov_now = ov_in & ~overvoltage_disable_reg;
  assign uv_now = uv_in & ~undervoltage_disable_reg;

  localparam int CNT_W = hsfs_pkg::CNT_W;
  function automatic logic [CNT_W-1:0] trip_cycles(input logic [1:0] s);
    case (s)
      2'h0:    trip_cycles = CNT_W'(hsfs_pkg::TRIP_DLY0_CYC);
      2'h1:    trip_cycles = CNT_W'(hsfs_pkg::TRIP_DLY1_CYC);
      2'h2:    trip_cycles = CNT_W'(hsfs_pkg::TRIP_DLY2_CYC);
      default: trip_cycles = CNT_W'(hsfs_pkg::TRIP_DLY3_CYC);
    endcase
  endfunction

  // ==========================================================
  // per output protection
  logic [1:0] cmd_on, ot_now, ol_now, ocl_hit, och_hit;
  logic [1:0] oc_latch_reg, uv_latch_reg, on_next, oc_trip;
  logic [CNT_W-1:0] oc_cnt_reg [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_out
      assign cmd_on[gi]  = dir_in[gi] | serial_on_reg[gi];
      assign ot_now[gi]  = ot_in[gi] & cmd_on[gi];
      assign ol_now[gi]  = ol_in[gi] & gl_in[gi] & ~switch_on_out[gi]
                         & ~open_load_disable_reg[gi];
      assign ocl_hit[gi] = ocl_in[gi*8 + low_lvl_reg[gi]];
      assign och_hit[gi] = och_in[gi*2 + high_lvl_reg[gi]];
      assign oc_trip[gi] = och_hit[gi]
                         | (ocl_hit[gi] && oc_cnt_reg[gi] >= trip_cycles(dly_reg[gi]));
      always_ff @(posedge sys_clk_in) begin
        if (rst_in || !ocl_hit[gi] || !switch_on_out[gi]) begin
          oc_cnt_reg[gi] <= '0;
        end else if (oc_cnt_reg[gi] != '1) begin
          oc_cnt_reg[gi] <= oc_cnt_reg[gi] + CNT_W'(1);
        end
      end
      always_ff @(posedge sys_clk_in) begin
        if (rst_in || !cmd_on[gi]) begin
          oc_latch_reg[gi] <= 1'h0;
        end else if (switch_on_out[gi] && oc_trip[gi]) begin
          oc_latch_reg[gi] <= 1'h1;
        end
      end
      always_ff @(posedge sys_clk_in) begin
        if (rst_in || !cmd_on[gi]) begin
          uv_latch_reg[gi] <= 1'h0;
        end else if (uv_now) begin
          uv_latch_reg[gi] <= 1'h1;
        end
      end
      assign on_next[gi] = cmd_on[gi] & ~oc_latch_reg[gi] & ~oc_trip[gi]
                         & ~uv_latch_reg[gi] & ~uv_now & ~ov_now & ~ot_now[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      switch_on_out <= 2'h0;
    end else begin
      switch_on_out <= on_next;
    end
  end

  // ==========================================================
  // fault pin
  logic fault_now;
  assign fault_now = |ot_now | |ol_now | |oc_latch_reg | ov_now | uv_now
                   | |uv_latch_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fault_pin_n_out <= 1'h1;
    end else begin
      fault_pin_n_out <= ~fault_now;
    end
  end

  // ==========================================================
  // sticky status; a new event wins over the clear of a read
  logic [7:0] set_vec, clr_vec;
  assign set_vec = {oc_latch_reg, ot_now, ol_now, ov_now, uv_now};
  assign clr_vec = frame_ok ? snap_reg : 8'h00;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status_out <= 8'h00;
    end else begin
      status_out <= set_vec | (status_out & ~clr_vec);
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      snap_reg <= 8'h00;
    end else if (cs_fall) begin
      snap_reg <= status_out;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_cs_fall;
    cs_prev_reg && !cs_s;
  endsequence
  sequence s_high_hit;
    och_hit[0] && switch_on_out[0] && cmd_on[0];
  endsequence
  chk_snap_load: assert property (s_cs_fall |=> snap_reg == $past(status_out))
    else $error("snapshot not loaded at chip select fall");
  chk_high_trip: assert property (s_high_hit |=> !switch_on_out[0] && oc_latch_reg[0])
    else $error("high trip did not latch off");
  chk_oc_hold: assert property (oc_latch_reg[0] && cmd_on[0] |=> !switch_on_out[0])
    else $error("latched output came back on");
  chk_fault_pin: assert property (fault_now |=> !fault_pin_n_out)
    else $error("fault pin not pulled low");
  chk_ot_flag: assert property (ot_now[0] |=> status_out[hsfs_pkg::ST_OT0])
    else $error("overtemp flag not set");
  chk_ov_bit: assert property (ov_in && !overvoltage_disable_reg
                               |=> status_out[hsfs_pkg::ST_OV] && switch_on_out == 2'h0)
    else $error("overvoltage not reported or output on");
  chk_overvoltage_disable: assert property (overvoltage_disable_reg && ov_in && cmd_on[0]
                               && !uv_now && !uv_latch_reg[0] && !ot_now[0]
                               && !oc_latch_reg[0] && !oc_trip[0] |=> switch_on_out[0])
    else $error("overvoltage seen while disabled");
  chk_undervoltage_disable: assert property (undervoltage_disable_reg
                               && !status_out[hsfs_pkg::ST_UV] |=> !status_out[hsfs_pkg::ST_UV])
    else $error("undervoltage seen while disabled");
  chk_cfg_reset: assert property (!vdd_ok |=> serial_on_reg == 2'h0
                                  && !overvoltage_disable_reg)
    else $error("configuration not reset on supply loss");
  chk_ol_off: assert property (switch_on_out[0] |-> !ol_now[0])
    else $error("open load sensed while on");
  chk_uv_release: assert property (!cmd_on[0] && !cmd_on[1] && !uv_in && !ov_in
                                   && ot_in == 2'h0 && ol_now == 2'h0 && oc_latch_reg == 2'h0
                                   && uv_latch_reg == 2'h0
                                   |=> fault_pin_n_out)
    else $error("fault pin not released");
  chk_uv_off: assert property (uv_now
                               |=> switch_on_out == 2'h0 && status_out[hsfs_pkg::ST_UV]
                               && !fault_pin_n_out)
    else $error("undervoltage did not switch off");
  chk_pin_release: assert property (!fault_now |=> fault_pin_n_out)
    else $error("fault pin held without a fault");
  chk_flag_clear: assert property (frame_ok && snap_reg[hsfs_pkg::ST_UV] && !uv_now
                                   |=> !status_out[hsfs_pkg::ST_UV])
    else $error("reported flag not cleared by frame");
  chk_cfg_default: assert property (!vdd_ok
                                    |=> dly_reg[0] == hsfs_pkg::DLY_RST
                                    && low_lvl_reg[1] == hsfs_pkg::LOW_LVL_RST
                                    && high_lvl_reg == {2{hsfs_pkg::HI_LVL_RST}})
    else $error("protection settings not at default");
  sequence s_cmd_drop;
    cmd_on[0] ##1 !cmd_on[0];
  endsequence
  chk_latch_rearm: assert property (s_cmd_drop
                                    |=> !oc_latch_reg[0] && !uv_latch_reg[0])
    else $error("latch not cleared by command off");

  // ==========================================================
  // checks on configuration frames
  chk_serial_cfg: assert property (frame_ok && vdd_ok
                                   && cmd[6:4] == hsfs_pkg::CMD_OUT
                                   |=> serial_on_reg == {cmd[hsfs_pkg::OUT_ON1],
                                                         cmd[hsfs_pkg::OUT_ON0]})
    else $error("serial command not taken");
  chk_trip_cfg: assert property (frame_ok && vdd_ok
                                 && cmd[6:4] == hsfs_pkg::CMD_TRIP
                                 |=> low_lvl_reg[sel] == cmd[2:0]
                                 && high_lvl_reg[sel] == cmd[hsfs_pkg::TRIP_HI])
    else $error("trip levels not taken");
  chk_sup_cfg: assert property (frame_ok && vdd_ok && sel
                                && cmd[6:4] == hsfs_pkg::CMD_SUP
                                |=> overvoltage_disable_reg == cmd[hsfs_pkg::SUP_OVD]
                                && undervoltage_disable_reg == cmd[hsfs_pkg::SUP_UVD])
    else $error("supply disables not taken");

  // ==========================================================
  // checks repeated for each output
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chk
      chk_low_trip: assert property (ocl_hit[gi] && switch_on_out[gi]
                                     && oc_cnt_reg[gi] >= trip_cycles(dly_reg[gi])
                                     |=> !switch_on_out[gi])
        else $error("low trip did not switch off");
      chk_ot_gate: assert property (!cmd_on[gi] |-> !ot_now[gi])
        else $error("overtemp sensed while commanded off");
      chk_ot_off: assert property (ot_now[gi] |=> !switch_on_out[gi])
        else $error("overtemp did not switch off");
      chk_ol_flag: assert property (ol_now[gi] |=> status_out[hsfs_pkg::ST_OL0 + gi])
        else $error("open load flag not set");
      chk_ol_mask: assert property (open_load_disable_reg[gi] |-> !ol_now[gi])
        else $error("open load sensed while disabled");
      chk_oc_flag: assert property (oc_latch_reg[gi]
                                    |=> status_out[hsfs_pkg::ST_OC0 + gi])
        else $error("over-current flag not set");
      chk_uv_hold: assert property (uv_latch_reg[gi] && cmd_on[gi]
                                    |=> !switch_on_out[gi] && !fault_pin_n_out)
        else $error("latched undervoltage released early");
      chk_uv_free: assert property (!cmd_on[gi] |=> !uv_latch_reg[gi])
        else $error("undervoltage latched with command low");
      chk_cmd_follow: assert property (cmd_on[gi] && !fault_now && !oc_trip[gi]
                                       |=> switch_on_out[gi])
        else $error("commanded output not on");
    end
  endgenerate
endmodule

/* File: verif/hsfs_spi_master.sv */
// Purpose: serial host model on the far side of the supervisor link
// Assumes: 6 ns link clock, sclk idle low and gated to frames
// Notes:   SO sampled before each rising sclk, SI driven low after each frame
module hsfs_spi_master (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lclk;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
    lclk     = 1'b0;
    #1.3;
    forever #3 lclk = ~lclk;
  end
  // ==========================================================
  // one frame of nb bits, MSB first; sclk low at both cs edges
  task automatic xfer(input logic [7:0] cmd, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge lclk);
    cs_n_out <= 1'b0;
    si_out   <= cmd[7];
    repeat (4) @(posedge lclk);
    for (int i = 0; i < nb; i++) begin
      rd[7-i] = so_in;
      sclk_out <= 1'b1;
      @(posedge lclk);
      sclk_out <= 1'b0;
      @(posedge lclk);
      si_out <= (i < 7) ? cmd[6-i] : 1'b0;
      @(posedge lclk);
    end
    cs_n_out <= 1'b1;
    si_out   <= 1'b0;
    repeat (4) @(posedge lclk);
  endtask
endmodule

/* File: verif/hsfs_supervisor_test.sv */
// Purpose: self-checking bench for the high side fault supervisor
// Assumes: 4 ns system clock, host model on its own 6 ns link clock
// Notes:   table of plain fault cases, then latching and config cases
module hsfs_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [1:0] di;
    logic [1:0] ot;
    logic       ov;
    logic       sl;
    logic [1:0] ol;
    logic [1:0] gl;
    logic [1:0] sw;
    logic       fn;
    logic [7:0] st;
  } hsfs_row_t;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        lsok    = 1'b1;
  logic [1:0]  di      = 2'h0;
  logic [1:0]  ot      = 2'h0;
  logic        ov      = 1'b0;
  logic        sl      = 1'b0;
  logic [1:0]  ol      = 2'h0;
  logic [1:0]  gl      = 2'h0;
  logic [15:0] lc      = 16'h0000;
  logic [3:0]  hc      = 4'h0;
  logic        sclk;
  logic        csn;
  logic        si;
  logic        so;
  logic        soe_n;
  logic [1:0]  sw;
  logic        fn;
  logic [7:0]  st;
  logic [7:0]  rd;
  int          err_total = 0;
  int          n_checks  = 0;
  hsfs_row_t   rows [7] = '{
    '{2'h3, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0, 2'h3, 1'h1, 8'h00},
    '{2'h1, 2'h1, 1'h0, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0, 8'h10},
    '{2'h0, 2'h3, 1'h0, 1'h0, 2'h0, 2'h3, 2'h0, 1'h1, 8'h00},
    '{2'h3, 2'h0, 1'h1, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0, 8'h02},
    '{2'h0, 2'h0, 1'h0, 1'h0, 2'h1, 2'h3, 2'h0, 1'h0, 8'h04},
    '{2'h3, 2'h0, 1'h0, 1'h0, 2'h3, 2'h0, 2'h3, 1'h1, 8'h00},
    '{2'h0, 2'h0, 1'h0, 1'h1, 2'h0, 2'h3, 2'h0, 1'h0, 8'h01}};
  always #2 sys_clk = ~sys_clk;
  hsfs_supervisor i_dut (
    .sys_clk_in         (sys_clk),
    .rst_in             (rst),
    .logic_supply_ok_in (lsok),
    .direct_inputs_in   (di),
    .overtemp_in        (ot),
    .overvolt_in        (ov),
    .supply_low_in      (sl),
    .open_load_in       (ol),
    .gate_low_in        (gl),
    .low_trip_cmp_in    (lc),
    .high_trip_cmp_in   (hc),
    .spi_sclk_in        (sclk),
    .spi_cs_n_in        (csn),
    .spi_si_in          (si),
    .spi_so_out         (so),
    .spi_so_oe_n_out    (soe_n),
    .switch_on_out      (sw),
    .fault_pin_n_out    (fn),
    .status_out         (st)
  );
  hsfs_spi_master i_host (
    .sclk_out (sclk),
    .cs_n_out (csn),
    .si_out   (si),
    .so_in    (so)
  );
  // ==========================================================
  // shared helpers
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic expect3(input logic [1:0] e_sw, input logic e_fn, input logic [7:0] e_st);
    chk("switch_on", {6'h00, e_sw}, {6'h00, sw});
    chk("fault_pin_n", {7'h00, e_fn}, {7'h00, fn});
    chk("status", e_st, st);
    chk("so_oe_n", 8'h01, {7'h00, soe_n});
  endtask
  task automatic drive(input logic [1:0] d, o, input logic v, s, input logic [1:0] l, g);
    @(posedge sys_clk);
    di <= d;
    ot <= o;
    ov <= v;
    sl <= s;
    ol <= l;
    gl <= g;
  endtask
  task automatic send(input logic [7:0] cmd);
    i_host.xfer(cmd, 8, rd);
    tk(10);
  endtask
  task automatic rd_clear(input logic [7:0] e);
    send(8'h00);
    chk("snapshot", e, rd);
    chk("status", 8'h00, st);
  endtask
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    tk(16);
    rst <= 1'b0;
    tk(2);
    expect3(2'h0, 1'h1, 8'h00);
    foreach (rows[k]) begin
      drive(rows[k].di, rows[k].ot, rows[k].ov, rows[k].sl, rows[k].ol, rows[k].gl);
      tk(10);
      expect3(rows[k].sw, rows[k].fn, rows[k].st);
      drive(rows[k].di, 2'h0, 1'h0, 1'h0, 2'h0, rows[k].gl);
      tk(10);
      expect3(rows[k].di, 1'h1, rows[k].st);
      rd_clear(rows[k].st);
      drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
      tk(6);
    end
    send(8'h15);
    chk("serial_on", 8'h03, {6'h00, sw});
    send(8'h10);
    drive(2'h1, 2'h0, 1'h0, 1'h1, 2'h0, 2'h0);
    tk(10);
    expect3(2'h0, 1'h0, 8'h01);
    drive(2'h1, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    tk(10);
    expect3(2'h0, 1'h0, 8'h01);
    i_host.xfer(8'h00, 4, rd);
    tk(10);
    chk("status", 8'h01, st);
    drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    drive(2'h1, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    tk(10);
    expect3(2'h1, 1'h1, 8'h01);
    rd_clear(8'h01);
    hc <= 4'h1;
    tk(5);
    expect3(2'h0, 1'h0, 8'h40);
    hc <= 4'h0;
    tk(10);
    expect3(2'h0, 1'h0, 8'h40);
    drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    drive(2'h1, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    tk(10);
    rd_clear(8'h40);
    send(8'h23);
    send(8'h31);
    lc <= 16'h0001;
    tk(80);
    chk("switch_on", 8'h01, {6'h00, sw});
    lc <= 16'h000F;
    tk(40);
    chk("switch_on", 8'h01, {6'h00, sw});
    tk(30);
    expect3(2'h0, 1'h0, 8'h40);
    lc <= 16'h0000;
    drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    tk(10);
    rd_clear(8'h40);
    send(8'hE3);
    send(8'h38);
    drive(2'h3, 2'h0, 1'h1, 1'h1, 2'h0, 2'h0);
    tk(10);
    expect3(2'h3, 1'h1, 8'h00);
    drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h1, 2'h3);
    tk(10);
    expect3(2'h0, 1'h1, 8'h00);
    drive(2'h3, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    lsok <= 1'b0;
    tk(10);
    chk("switch_on", 8'h03, {6'h00, sw});
    drive(2'h3, 2'h0, 1'h1, 1'h0, 2'h0, 2'h0);
    tk(10);
    chk("switch_on", 8'h00, {6'h00, sw});
    lsok <= 1'b1;
    drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h1, 2'h3);
    tk(10);
    expect3(2'h0, 1'h0, 8'h06);
    drive(2'h0, 2'h0, 1'h0, 1'h0, 2'h0, 2'h0);
    tk(10);
    rd_clear(8'h06);
    conclude();
  end
endmodule
